// ==== design/afe_io_pkg.sv ====
// Constants, register map and carrier types for the analog front-end control block.
package afe_io_pkg;

    // ==========================================================
    // Register offsets and layout
    localparam logic [5:0] ADDR_CONVERTER_CONTROL = 6'h01;
    localparam logic [5:0] ADDR_IO_CONTROL_FIRST = 6'h03;
    localparam logic [5:0] ADDR_SETUP_FIRST = 6'h19;
    localparam logic [5:0] ADDR_SETUP_LAST = 6'h20;
    localparam int SETUP_COUNT = 8;

    localparam logic [15:0] CONVERTER_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CONVERTER_CONTROL_MASK = 16'h1fff;
    localparam logic [23:0] IO_CONTROL_FIRST_RESET = 24'h000000;
    localparam logic [23:0] IO_CONTROL_FIRST_MASK = 24'hffbfff;
    localparam logic [15:0] SETUP_RESET = 16'h0860;
    localparam logic [15:0] SETUP_MASK = 16'h0fff;

    // Converter control fields.
    localparam int REF_ENABLE_BIT = 8;

    // Setup configuration fields.
    localparam int SETUP_BIPOLAR_BIT = 11;
    localparam int SETUP_POS_BUF_BIT = 6;
    localparam int SETUP_NEG_BUF_BIT = 5;
    localparam int SETUP_REF_SEL_LSB = 3;
    localparam int SETUP_GAIN_LSB = 0;

    // Input/output control fields.
    localparam int GENERAL_VALUE_LSB = 20;
    localparam int GENERAL_ENABLE_LSB = 16;
    localparam int BRIDGE_SWITCH_BIT = 15;
    localparam int EXC_B_MAG_LSB = 11;
    localparam int EXC_A_MAG_LSB = 8;
    localparam int EXC_B_PIN_LSB = 4;
    localparam int EXC_A_PIN_LSB = 0;
    localparam int GENERAL_COUNT = 4;

    // Reference source codes.
    localparam logic [1:0] REF_SEL_PAIR_A = 2'h0;
    localparam logic [1:0] REF_SEL_PAIR_B = 2'h1;
    localparam logic [1:0] REF_SEL_INTERNAL = 2'h2;

    // Gain codes that bound the stage usage.
    localparam logic [2:0] GAIN_CODE_ONE = 3'h0;
    localparam logic [2:0] GAIN_CODE_EIGHT = 3'h3;

    localparam int RESULT_WIDTH = 24;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic [2:0] gain_amplifier_field;
        logic stage_bypass;
        logic stage_single;
        logic stage_double;
        logic positive_input_buffer_enable;
        logic negative_input_buffer_enable;
        logic select_pair_a;
        logic select_pair_b;
        logic select_internal;
        logic internal_reference_on;
        logic reference_output_pin;
        logic bipolar;
    } afe_ctrl_t;

    typedef struct packed {
        logic [2:0] excitation_a_magnitude;
        logic [2:0] excitation_b_magnitude;
        logic [3:0] excitation_a_pin_select;
        logic [3:0] excitation_b_pin_select;
        logic bridge_switch_control;
    } excitation_ctrl_t;

    typedef struct packed {
        logic [15:0] converter_control;
        logic [23:0] io_control_first;
        logic [SETUP_COUNT-1:0][15:0] setup;
        logic [2:0] sync_pipe;
        logic sync_level;
        logic restart;
        logic [23:0] rdata;
        logic [RESULT_WIDTH-1:0] code;
        logic code_valid;
    } top_state_t;

endpackage

// ==== design/gain_stage_decode.sv ====
// Gain code decode into amplifier stage steering and automatic buffer enable.
`timescale 1ns/1ps
`default_nettype none
module gain_stage_decode
    import afe_io_pkg::*;
(
    input wire logic [2:0] gain_code,
    input wire logic pos_buf_bit,
    input wire logic neg_buf_bit,
    output logic stage_bypass,
    output logic stage_single,
    output logic stage_double,
    output logic pos_buf_on,
    output logic neg_buf_on
);

    always_comb begin
        // Codes zero to seven mean gains one to 128 in powers of two.
        stage_bypass = (gain_code == GAIN_CODE_ONE);
        stage_single = (gain_code != GAIN_CODE_ONE) && (gain_code <= GAIN_CODE_EIGHT);
        stage_double = (gain_code > GAIN_CODE_EIGHT);
        pos_buf_on = pos_buf_bit | (gain_code != GAIN_CODE_ONE);
        neg_buf_on = neg_buf_bit | (gain_code != GAIN_CODE_ONE);
    end

endmodule
`default_nettype wire

// ==== design/afe_io_control.sv ====
// Register bank and control logic for the converter front end and its input/output pins.
`timescale 1ns/1ps
`default_nettype none
module afe_io_control
    import afe_io_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [5:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [23:0] reg_rdata,
    input wire logic [2:0] active_setup,
    input wire logic sync_pin_n,
    input wire logic [RESULT_WIDTH-1:0] raw_result,
    input wire logic raw_valid,
    output logic [RESULT_WIDTH-1:0] result_code,
    output logic result_valid,
    output logic restart_pulse,
    output afe_ctrl_t afe_ctrl,
    output excitation_ctrl_t excitation_ctrl,
    output logic [GENERAL_COUNT-1:0] general_out,
    output logic [GENERAL_COUNT-1:0] general_oe_n
);

    // ==========================================================
    // Reset release
    logic [1:0] rst_pipe;
    logic rst_sync_n;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    // ==========================================================
    // State
    top_state_t state;
    top_state_t next_state;
    logic [15:0] cur_setup;
    logic setup_hit;
    logic [2:0] setup_index;
    logic [5:0] setup_offset;
    logic sync_falling;

    assign cur_setup = state.setup[active_setup];
    assign setup_offset = reg_addr - ADDR_SETUP_FIRST;
    assign setup_index = setup_offset[2:0];
    assign setup_hit = (reg_addr >= ADDR_SETUP_FIRST) && (reg_addr <= ADDR_SETUP_LAST);

    always_comb begin
        next_state = state;
        sync_falling = 1'b0;
        next_state.restart = 1'b0;
        // The pin passes three flops; a level change counts once the last two agree.
        next_state.sync_pipe = {state.sync_pipe[1:0], sync_pin_n};
        if (state.sync_pipe[1] == state.sync_pipe[2]) begin
            next_state.sync_level = state.sync_pipe[2];
            sync_falling = state.sync_level && !state.sync_pipe[2];
        end
        if (sync_falling) begin
            next_state.restart = 1'b1;
        end
        if (reg_write) begin
            if (reg_addr == ADDR_CONVERTER_CONTROL) begin
                next_state.converter_control = reg_wdata[15:0] & CONVERTER_CONTROL_MASK;
                next_state.restart = 1'b1;
            end else if (reg_addr == ADDR_IO_CONTROL_FIRST) begin
                next_state.io_control_first = reg_wdata & IO_CONTROL_FIRST_MASK;
            end else if (setup_hit) begin
                next_state.setup[setup_index] = reg_wdata[15:0] & SETUP_MASK;
                next_state.restart = 1'b1;
            end
        end
        if (reg_read) begin
            if (reg_addr == ADDR_CONVERTER_CONTROL) begin
                next_state.rdata = {8'h00, state.converter_control};
            end else if (reg_addr == ADDR_IO_CONTROL_FIRST) begin
                next_state.rdata = state.io_control_first;
            end else if (setup_hit) begin
                next_state.rdata = {8'h00, state.setup[setup_index]};
            end else begin
                next_state.rdata = 24'h000000;
            end
        end
        next_state.code_valid = raw_valid;
        if (raw_valid) begin
            // The modulator result is two's complement when bipolar, unsigned when unipolar.
            if (cur_setup[SETUP_BIPOLAR_BIT]) begin
                next_state.code = {~raw_result[RESULT_WIDTH-1], raw_result[RESULT_WIDTH-2:0]};
            end else begin
                next_state.code = raw_result;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state.converter_control <= CONVERTER_CONTROL_RESET;
            state.io_control_first <= IO_CONTROL_FIRST_RESET;
            state.setup <= {SETUP_COUNT{SETUP_RESET}};
            state.sync_pipe <= 3'h7;
            state.sync_level <= 1'b1;
            state.restart <= 1'b0;
            state.rdata <= 24'h000000;
            state.code <= 24'h000000;
            state.code_valid <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;
    assign result_code = state.code;
    assign result_valid = state.code_valid;
    assign restart_pulse = state.restart;

    // ==========================================================
    // Front-end steering
    logic [1:0] ref_sel;
    // The decoder drives local nets so that each field of the output struct has one driver.
    logic dec_bypass;
    logic dec_single;
    logic dec_double;
    logic dec_pos_buf;
    logic dec_neg_buf;

    assign ref_sel = cur_setup[SETUP_REF_SEL_LSB +: 2];

    gain_stage_decode u_gain (
        .gain_code(cur_setup[SETUP_GAIN_LSB +: 3]),
        .pos_buf_bit(cur_setup[SETUP_POS_BUF_BIT]),
        .neg_buf_bit(cur_setup[SETUP_NEG_BUF_BIT]),
        .stage_bypass(dec_bypass),
        .stage_single(dec_single),
        .stage_double(dec_double),
        .pos_buf_on(dec_pos_buf),
        .neg_buf_on(dec_neg_buf)
    );

    always_comb begin
        afe_ctrl.gain_amplifier_field = cur_setup[SETUP_GAIN_LSB +: 3];
        afe_ctrl.stage_bypass = dec_bypass;
        afe_ctrl.stage_single = dec_single;
        afe_ctrl.stage_double = dec_double;
        afe_ctrl.positive_input_buffer_enable = dec_pos_buf;
        afe_ctrl.negative_input_buffer_enable = dec_neg_buf;
        afe_ctrl.select_pair_a = (ref_sel == REF_SEL_PAIR_A);
        afe_ctrl.select_pair_b = (ref_sel == REF_SEL_PAIR_B);
        afe_ctrl.internal_reference_on = state.converter_control[REF_ENABLE_BIT];
        // The internal source only reaches the converter when both selected and powered.
        afe_ctrl.select_internal = (ref_sel == REF_SEL_INTERNAL) && state.converter_control[REF_ENABLE_BIT];
        afe_ctrl.reference_output_pin = state.converter_control[REF_ENABLE_BIT];
        afe_ctrl.bipolar = cur_setup[SETUP_BIPOLAR_BIT];
    end

    // Excitation fields come only from the input/output register, never the reference enable.
    always_comb begin
        excitation_ctrl.excitation_a_magnitude = state.io_control_first[EXC_A_MAG_LSB +: 3];
        excitation_ctrl.excitation_b_magnitude = state.io_control_first[EXC_B_MAG_LSB +: 3];
        excitation_ctrl.excitation_a_pin_select = state.io_control_first[EXC_A_PIN_LSB +: 4];
        excitation_ctrl.excitation_b_pin_select = state.io_control_first[EXC_B_PIN_LSB +: 4];
        excitation_ctrl.bridge_switch_control = state.io_control_first[BRIDGE_SWITCH_BIT];
    end

    // ==========================================================
    // General outputs
    genvar gi;
    generate
        for (gi = 0; gi < GENERAL_COUNT; gi++) begin : g_general
            assign general_oe_n[gi] = ~state.io_control_first[GENERAL_ENABLE_LSB + gi];
            assign general_out[gi] = state.io_control_first[GENERAL_VALUE_LSB + gi];
        end
    endgenerate

    // ==========================================================
    // Checks
    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        state.io_control_first[14] == 1'b0)
        else $error("Fixed-zero bit of the io control register is set.");

    a_io_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (clk_en && reg_write && reg_addr == ADDR_IO_CONTROL_FIRST)
        |=> excitation_ctrl.excitation_b_magnitude == $past(reg_wdata[13:11])
            && excitation_ctrl.excitation_a_magnitude == $past(reg_wdata[10:8]))
        else $error("Excitation magnitudes do not follow the written value.");

    a_bridge_switch: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (clk_en && reg_write && reg_addr == ADDR_IO_CONTROL_FIRST)
        |=> excitation_ctrl.bridge_switch_control == $past(reg_wdata[15]))
        else $error("Bridge switch does not follow the written bit.");

    a_general_drive: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (clk_en && reg_write && reg_addr == ADDR_IO_CONTROL_FIRST)
        |=> general_out == $past(reg_wdata[23:20]) && general_oe_n == ~$past(reg_wdata[19:16]))
        else $error("General outputs do not follow the written value.");

    a_internal_gated: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        afe_ctrl.select_internal |-> state.converter_control[REF_ENABLE_BIT])
        else $error("Internal reference used while disabled.");

    a_one_stage_mode: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        $onehot({afe_ctrl.stage_bypass, afe_ctrl.stage_single, afe_ctrl.stage_double}))
        else $error("Amplifier stage steering is not exactly one mode.");

    a_auto_buffer: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        !afe_ctrl.stage_bypass |-> afe_ctrl.positive_input_buffer_enable
            && afe_ctrl.negative_input_buffer_enable)
        else $error("Input buffers off while gain exceeds one.");

    a_bipolar_code: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (clk_en && raw_valid && cur_setup[SETUP_BIPOLAR_BIT] && raw_result == 24'h000000)
        |=> result_valid && result_code == 24'h800000)
        else $error("Bipolar zero input is not midscale code.");

    a_unipolar_code: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (clk_en && raw_valid && !cur_setup[SETUP_BIPOLAR_BIT])
        |=> result_valid && result_code == $past(raw_result))
        else $error("Unipolar code is not straight binary.");

    a_restart_write: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (clk_en && reg_write && (reg_addr == ADDR_CONVERTER_CONTROL || setup_hit)) |=> restart_pulse)
        else $error("Mode or configuration write gave no restart.");

    a_restart_sync: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (clk_en && sync_falling) |=> restart_pulse)
        else $error("Sync pin pulse gave no restart.");

    // ==========================================================
    // Checks on register storage and read-back
    // A frozen cycle must leave every stored bit exactly as it was.
    a_clk_freeze: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        !clk_en |=> state == $past(state))
        else $error("State changed while clock enable was low.");

    a_io_read_back: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (clk_en && reg_read && reg_addr == ADDR_IO_CONTROL_FIRST)
        |=> reg_rdata == $past(state.io_control_first) && reg_rdata[14] == 1'b0)
        else $error("Io control read-back is wrong.");

    a_unmapped_read: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (clk_en && reg_read && reg_addr != ADDR_CONVERTER_CONTROL
            && reg_addr != ADDR_IO_CONTROL_FIRST && !setup_hit)
        |=> reg_rdata == 24'h000000)
        else $error("Unmapped read returned nonzero data.");

    a_setup_lands: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (clk_en && reg_write && setup_hit)
        |=> state.setup[$past(setup_index)] == ($past(reg_wdata[15:0]) & SETUP_MASK))
        else $error("Setup write did not land.");

    a_conv_mask: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        state.converter_control[15:13] == 3'h0)
        else $error("Fixed-zero converter control bits are set.");

    // ==========================================================
    // Checks on front-end steering
    a_gain_field: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        afe_ctrl.gain_amplifier_field == cur_setup[SETUP_GAIN_LSB +: 3])
        else $error("Gain field does not follow the active setup.");

    a_stage_single: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        afe_ctrl.stage_single |-> afe_ctrl.gain_amplifier_field != GAIN_CODE_ONE
            && afe_ctrl.gain_amplifier_field <= GAIN_CODE_EIGHT)
        else $error("Single stage used outside gains two to eight.");

    a_ref_exclusive: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        $onehot0({afe_ctrl.select_pair_a, afe_ctrl.select_pair_b, afe_ctrl.select_internal}))
        else $error("More than one reference source selected.");

    a_polarity_follow: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        afe_ctrl.bipolar == cur_setup[SETUP_BIPOLAR_BIT])
        else $error("Polarity does not follow the active setup.");

    // ==========================================================
    // Checks on excitation, general outputs, restart and result valid
    a_excitation_pins: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (clk_en && reg_write && reg_addr == ADDR_IO_CONTROL_FIRST)
        |=> excitation_ctrl.excitation_a_pin_select == $past(reg_wdata[3:0])
            && excitation_ctrl.excitation_b_pin_select == $past(reg_wdata[7:4]))
        else $error("Excitation pin selects do not follow the write.");

    a_excitation_free: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (clk_en && reg_write && reg_addr == ADDR_CONVERTER_CONTROL) |=> $stable(excitation_ctrl))
        else $error("Excitation moved on a converter control write.");

    a_general_release: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        general_oe_n == ~state.io_control_first[GENERAL_ENABLE_LSB +: GENERAL_COUNT])
        else $error("General output enable does not follow its bit.");

    // Only mode and configuration writes and sync pin falls restart; io writes must leave the filter running.
    a_io_no_restart: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (clk_en && reg_write && reg_addr == ADDR_IO_CONTROL_FIRST && !sync_falling)
        |=> !restart_pulse)
        else $error("Io control write gave a restart.");

    a_result_pulse: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        (clk_en && !raw_valid) |=> !result_valid)
        else $error("Result valid stood without a new result.");

endmodule
`default_nettype wire

// ==== sim/afe_host_model.sv ====
// Host model that programs the front-end registers and pulses the sync pin.
`timescale 1ns/1ps
`default_nettype none
module afe_host_model (
    input wire logic ref_clk,
    input wire logic [23:0] reg_rdata,
    output logic [5:0] reg_addr,
    output logic [23:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    output logic sync_pin_n
);
    // ==========================================================
    // Register access and sync tasks
    initial begin
        reg_addr = 6'h00;
        reg_wdata = 24'h000000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        sync_pin_n = 1'b1;
    end

    // Released lines carry the inverse of the last value so stale data is never trusted.
    task automatic write_reg(input logic [5:0] a, input logic [23:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge ref_clk);
        reg_write = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic read_reg(input logic [5:0] a, output logic [23:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge ref_clk);
        reg_read = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask

    // After switching an external multiplexer the host restarts the converter.
    task automatic sync_pulse();
        @(negedge ref_clk);
        sync_pin_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        sync_pin_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== sim/analog_frontend_io_control_tb_top.sv ====
// Self-checking testbench for the front-end control register bank.
`timescale 1ns/1ps
`default_nettype none
module analog_frontend_io_control_tb_top;
    import afe_io_pkg::*;
    typedef struct packed {
        logic [23:0] wd;
        logic [14:0] exc;
        logic [3:0] go;
        logic [3:0] oen;
    } row_t;
    logic ref_clk, rst_n, clk_en, raw_valid, reg_write, reg_read, sync_pin_n;
    logic restart_pulse, result_valid;
    logic [2:0] active_setup;
    logic [5:0] reg_addr;
    logic [23:0] reg_wdata, reg_rdata, raw_result, result_code, rd;
    logic [3:0] general_out, general_oe_n;
    afe_ctrl_t afe_ctrl;
    excitation_ctrl_t excitation_ctrl;
    logic [2:0] iref;
    int n_errors = 0;
    int total_checks = 0;
    row_t rows [6] = '{'{24'hffffff, 15'h7fff, 4'hf, 4'h0}, '{24'h004000, 15'h0000, 4'h0, 4'hf},
        '{24'h5a8533, 15'h5067, 4'h5, 4'h5}, '{24'h3c3e21, 15'h6e24, 4'h3, 4'h3},
        '{24'h000800, 15'h0200, 4'h0, 4'hf}, '{24'h000100, 15'h1000, 4'h0, 4'hf}};
    logic [50:0] codes [6] = '{{3'h0, 24'h000000, 24'h000000}, {3'h0, 24'h800000, 24'h800000},
        {3'h0, 24'hffffff, 24'hffffff}, {3'h1, 24'h000000, 24'h800000},
        {3'h1, 24'h7fffff, 24'hffffff}, {3'h1, 24'h800000, 24'h000000}};

    afe_io_control afe_io_control_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .active_setup(active_setup), .sync_pin_n(sync_pin_n),
        .raw_result(raw_result), .raw_valid(raw_valid), .result_code(result_code),
        .result_valid(result_valid), .restart_pulse(restart_pulse), .afe_ctrl(afe_ctrl),
        .excitation_ctrl(excitation_ctrl), .general_out(general_out), .general_oe_n(general_oe_n));
    afe_host_model afe_host_model_i (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .sync_pin_n(sync_pin_n));
    assign iref = {afe_ctrl.select_internal, afe_ctrl.internal_reference_on, afe_ctrl.reference_output_pin};

    // ==========================================================
    // Clock, shared checks and closing report
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Counts restart pulses over a bounded number of cycles.
    task automatic count_rst(input int cyc, input int exp, input string nm);
        int cnt;
        cnt = 0;
        repeat (cyc) begin
            if (restart_pulse === 1'b1) cnt++;
            @(negedge ref_clk);
        end
        check(nm, 24'(cnt), 24'(exp));
    endtask

    task automatic convert(input logic [50:0] c);
        @(negedge ref_clk);
        active_setup = c[50:48];
        raw_result = c[47:24];
        raw_valid = 1'b1;
        @(negedge ref_clk);
        raw_valid = 1'b0;
        raw_result = ~c[47:24];
        check("bipolar", 24'(afe_ctrl.bipolar), 24'(c[48]));
        check("valid", 24'(result_valid), 24'h000001);
        check("code", result_code, c[23:0]);
        @(negedge ref_clk);
        check("valid_drop", 24'(result_valid), 24'h000000);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge ref_clk);
        n_errors++;
        print_verdict();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [2:0] g;
        rst_n = 1'b0;
        clk_en = 1'b1;
        active_setup = 3'h0;
        raw_result = 24'h000000;
        raw_valid = 1'b0;
        repeat (8) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        check("oe_rst", 24'(general_oe_n), 24'h00000f);
        afe_host_model_i.read_reg(ADDR_IO_CONTROL_FIRST, rd);
        check("io_rst", rd, IO_CONTROL_FIRST_RESET);
        afe_host_model_i.read_reg(ADDR_SETUP_FIRST, rd);
        check("setup_rst", rd, 24'(SETUP_RESET));
        afe_host_model_i.read_reg(6'h3f, rd);
        check("unmapped", rd, 24'h000000);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            afe_host_model_i.write_reg(ADDR_IO_CONTROL_FIRST, rows[i].wd);
            check("exc", 24'(excitation_ctrl), 24'(rows[i].exc));
            check("gout", 24'(general_out), 24'(rows[i].go));
            check("oen", 24'(general_oe_n), 24'(rows[i].oen));
            count_rst(3, 0, "io_no_restart");
            afe_host_model_i.read_reg(ADDR_IO_CONTROL_FIRST, rd);
            check("io_read", rd, rows[i].wd & 24'hffbfff);
        end
        $display("test io table done");
        for (int i = 0; i < 8; i++) begin
            g = 3'(i);
            afe_host_model_i.write_reg(ADDR_SETUP_FIRST, {16'h0000, 3'h0, g[1:0], g});
            check("gain", 24'(afe_ctrl.gain_amplifier_field), 24'(g));
            check("stage", 24'({afe_ctrl.stage_bypass, afe_ctrl.stage_single, afe_ctrl.stage_double}),
                (i == 0) ? 24'h4 : (i <= 8'd3) ? 24'h2 : 24'h1);
            check("buf", 24'({afe_ctrl.positive_input_buffer_enable, afe_ctrl.negative_input_buffer_enable}),
                (i == 0) ? 24'h0 : 24'h3);
            check("ref", 24'({afe_ctrl.select_pair_a, afe_ctrl.select_pair_b, afe_ctrl.select_internal}),
                (g[1:0] == 2'h0) ? 24'h4 : (g[1:0] == 2'h1) ? 24'h2 : 24'h0);
            count_rst(3, 1, "setup_restart");
        end
        $display("test gain done");
        afe_host_model_i.write_reg(ADDR_SETUP_FIRST, 24'h000010);
        check("int_sel_off", 24'(iref), 24'h0);
        afe_host_model_i.write_reg(ADDR_CONVERTER_CONTROL, 24'h000001 << REF_ENABLE_BIT);
        check("int_ref", 24'(iref), 24'h7);
        count_rst(3, 1, "conv_restart");
        afe_host_model_i.read_reg(ADDR_CONVERTER_CONTROL, rd);
        check("conv_read", rd, 24'h000100);
        afe_host_model_i.write_reg(ADDR_CONVERTER_CONTROL, 24'hffffff);
        afe_host_model_i.read_reg(ADDR_CONVERTER_CONTROL, rd);
        check("conv_mask", rd, 24'h001fff);
        afe_host_model_i.write_reg(ADDR_CONVERTER_CONTROL, 24'h000000);
        check("int_ref_off", 24'(iref), 24'h0);
        check("exc_keep", 24'(excitation_ctrl), 24'h001000);
        $display("test reference done");
        clk_en = 1'b0;
        afe_host_model_i.write_reg(ADDR_IO_CONTROL_FIRST, 24'hffffff);
        check("exc_freeze", 24'(excitation_ctrl), 24'h001000);
        check("oen_freeze", 24'(general_oe_n), 24'h00000f);
        clk_en = 1'b1;
        afe_host_model_i.write_reg(ADDR_SETUP_LAST, 24'hffffff);
        afe_host_model_i.read_reg(ADDR_SETUP_LAST, rd);
        check("setup_last", rd, 24'h000fff);
        $display("test freeze done");
        afe_host_model_i.write_reg(ADDR_SETUP_FIRST, 24'h000000);
        afe_host_model_i.write_reg(ADDR_SETUP_FIRST + 6'h01, 24'h000001 << SETUP_BIPOLAR_BIT);
        for (int i = 0; i < 6; i++) convert(codes[i]);
        $display("test coding done");
        afe_host_model_i.sync_pulse();
        count_rst(8, 1, "sync_restart");
        $display("test sync done");
        @(negedge ref_clk);
        rst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        check("oe_midrst", 24'(general_oe_n), 24'h00000f);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        afe_host_model_i.read_reg(ADDR_IO_CONTROL_FIRST, rd);
        check("io_midrst", rd, IO_CONTROL_FIRST_RESET);
        $display("test mid reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
